// *** hdl/pa_decode.sv ***
// Physical address decoder between processor core and memory/bus adapters.
// Assumes the core holds request inputs valid for the request cycle only.
`timescale 1ns/1ps
// What this block does
// - Takes a 32-bit virtual address from the processor.
// - Produces physical addresses of at most 30 bits.
// - Undecoded upper physical bits are ignored, never faulted.
// - With mapping off, drops virtual bits 31:30 and passes the rest.
// - Addresses below the limit go to memory space.
// - Addresses from the limit to the top go to I/O space.
// - Both spaces are byte addressed.
// - Memory takes byte, word, longword at any alignment.
// - I/O must take aligned longwords; other forms optional.
// - A 256 KB I/O window maps directly to 18-bit bus addresses.
// - The low 248 KB of the window is bus memory region.
// - Bus master accesses there translate via map registers.
// - Adapter region starts with a readable type code register.
module pa_decode
	import pa_decode_pkg::*;
#(
	parameter int DEC_BITS = PA_W,
	parameter logic [29:0] MEM_LIMIT = MEM_LIMIT_DEF,
	parameter logic [29:0] PBUS_BASE = PBUS_BASE_DEF,
	parameter logic [29:0] ADP_BASE = ADP_BASE_DEF,
	parameter logic [31:0] ADP_TYPE = ADP_TYPE_DEF,
	parameter bit IO_ANY_SIZE = 1'b0
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic [31:0] i_vaddr,
	input wire logic i_map_en,
	input wire logic [29:0] i_xlat_pa,
	input wire logic [1:0] i_size,
	input wire logic i_write,
	input wire logic i_map_we,
	input wire logic [8:0] i_map_idx,
	input wire logic [20:0] i_map_frame,
	input wire logic i_bm_req,
	input wire logic [17:0] i_bm_addr,
	output logic o_mem_sel,
	output logic o_io_sel,
	output logic o_pbus_sel,
	output logic o_pbus_mem,
	output logic o_cfg_sel,
	output logic [29:0] o_paddr,
	output logic [17:0] o_pbus_addr,
	output logic [1:0] o_size,
	output logic o_write,
	output logic o_err,
	output logic [31:0] o_cfg_data,
	output logic o_bm_valid,
	output logic o_bm_hit,
	output logic [29:0] o_bm_paddr
);

	////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic mem_sel;
		logic io_sel;
		logic pbus_sel;
		logic pbus_mem;
		logic cfg_sel;
		logic [29:0] paddr;
		logic [17:0] pbus_addr;
		logic [1:0] size;
		logic write;
		logic err;
		logic [31:0] cfg_data;
		logic bm_valid;
		logic bm_hit;
		logic [29:0] bm_paddr;
	} state_t;

	state_t cur;
	state_t next_cur;

	// Map registers, one page frame per 512-byte bus page
	logic [20:0] map_ram [0:511];
	logic [20:0] map_rd;

	// Only the implemented physical bits are kept
	function automatic logic [29:0] trim(input logic [29:0] a);
		logic [29:0] m;
		m = 30'h3FFFFFFF >> (PA_W - DEC_BITS);
		trim = a & m;
	endfunction

	// Natural alignment check for a reference
	function automatic logic aligned(input logic [1:0] sz,
			input logic [1:0] lo);
		case (sz)
			SZ_BYTE: aligned = 1'b1;
			SZ_WORD: aligned = ~lo[0];
			SZ_LONG: aligned = (lo == 2'h0);
			default: aligned = 1'b0;
		endcase
	endfunction

	// Type code register: fixed offset inside the adapter region
	function automatic logic cfg_hit(input logic [29:0] a);
		logic [29:0] ofs;
		ofs = a - trim(ADP_BASE);
		cfg_hit = ((ofs & ~ADP_CFG_MASK) == 30'h0)
			&& (ofs == ADP_CFG_OFS);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Address formation and space decode

	logic [29:0] pa;
	logic in_io;
	logic in_win;
	logic [29:0] win_ofs;
	logic io_ok;

	always_comb begin
		// Mapped path uses translated address; unmapped drops bits 31:30
		pa = trim(i_map_en ? i_xlat_pa : i_vaddr[29:0]);
		in_io = (pa >= trim(MEM_LIMIT));
		win_ofs = pa - trim(PBUS_BASE);
		in_win = in_io && (pa >= trim(PBUS_BASE))
			&& (win_ofs[29:18] == 12'h000);
		// Full I/O support is optional; default keeps the minimum
		io_ok = (i_size == SZ_LONG && pa[1:0] == 2'h0)
			|| (IO_ANY_SIZE && aligned(i_size, pa[1:0]));
	end

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_cur = cur;
		next_cur.mem_sel = 1'b0;
		next_cur.io_sel = 1'b0;
		next_cur.pbus_sel = 1'b0;
		next_cur.pbus_mem = 1'b0;
		next_cur.cfg_sel = 1'b0;
		next_cur.err = 1'b0;
		next_cur.bm_valid = 1'b0;
		if (i_req) begin
			next_cur.paddr = pa;
			next_cur.size = i_size;
			next_cur.write = i_write;
			if (!in_io) begin
				// Byte, word or longword, any alignment in memory space; SZ_BAD refused
				next_cur.mem_sel = (i_size != SZ_BAD);
				next_cur.err = (i_size == SZ_BAD);
			end else if (!io_ok) begin
				// Refused rather than split into partial accesses
				next_cur.err = 1'b1;
			end else if (in_win) begin
				next_cur.pbus_sel = 1'b1;
				next_cur.pbus_addr = win_ofs[17:0];
				next_cur.pbus_mem = (win_ofs[17:0] < PBUS_MEM_TOP);
			end else if (cfg_hit(pa) && !i_write) begin
				// Type code read, local answer
				next_cur.cfg_sel = 1'b1;
				next_cur.cfg_data = ADP_TYPE;
			end else begin
				next_cur.io_sel = 1'b1;
			end
		end
		// Bus master translation, answered the next cycle
		if (i_bm_req) begin
			next_cur.bm_valid = 1'b1;
			next_cur.bm_hit = (i_bm_addr < PBUS_MEM_TOP);
			next_cur.bm_paddr = trim({map_rd,
				i_bm_addr[MAP_PAGE_W-1:0]});
		end
	end

	assign map_rd = map_ram[i_bm_addr[17:MAP_PAGE_W]];

	////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// Map register writes; entries past the region are never used
	always_ff @(posedge i_mclk) begin
		if (i_map_we && i_map_idx < MAP_ENTRIES) begin
			map_ram[i_map_idx] <= i_map_frame;
		end
	end

	assign o_mem_sel = cur.mem_sel;
	assign o_io_sel = cur.io_sel;
	assign o_pbus_sel = cur.pbus_sel;
	assign o_pbus_mem = cur.pbus_mem;
	assign o_cfg_sel = cur.cfg_sel;
	assign o_paddr = cur.paddr;
	assign o_pbus_addr = cur.pbus_addr;
	assign o_size = cur.size;
	assign o_write = cur.write;
	assign o_err = cur.err;
	assign o_cfg_data = cur.cfg_data;
	assign o_bm_valid = cur.bm_valid;
	assign o_bm_hit = cur.bm_hit;
	assign o_bm_paddr = cur.bm_paddr;

	////////////////////////////////////////////////////////////////////
	// Checks

	a_unmapped_trunc: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		i_req && !i_map_en |=> o_paddr == trim($past(i_vaddr[29:0])))
		else $error("unmapped address not truncated");

	a_mapped_src: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		i_req && i_map_en |=> o_paddr == trim($past(i_xlat_pa)))
		else $error("mapped address not passed through");

	a_upper_ignored: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		i_req && !i_map_en && i_size == SZ_LONG && i_vaddr[1:0] == 2'h0
		|=> !o_err)
		else $error("aligned longword faulted on upper bits");

	a_mem_space: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		o_mem_sel |-> o_paddr < trim(MEM_LIMIT))
		else $error("memory select above limit");

	a_io_space: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		(o_io_sel || o_pbus_sel || o_cfg_sel) |-> o_paddr >= trim(MEM_LIMIT))
		else $error("I/O select below limit");

	a_io_answer: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		i_req && in_io && io_ok |=> o_io_sel || o_pbus_sel || o_cfg_sel)
		else $error("supported I/O reference not routed");

	a_pulse_drop: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		!i_req |=> !(o_mem_sel || o_io_sel || o_pbus_sel || o_cfg_sel
			|| o_err))
		else $error("target pulse without a reference");

	a_one_target: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		$onehot0({o_mem_sel, o_io_sel, o_pbus_sel, o_cfg_sel, o_err}))
		else $error("more than one target selected");

	a_mem_any: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		i_req && !in_io && i_size != SZ_BAD |=> o_mem_sel && !o_err)
		else $error("memory reference refused");

	a_size_pass: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		i_req |=> o_size == $past(i_size) && o_write == $past(i_write))
		else $error("reference size or direction lost");

	a_io_long: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		i_req && in_io && i_size == SZ_LONG && pa[1:0] == 2'h0
		|=> !o_err)
		else $error("aligned longword refused in I/O");

	a_win_claim: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		i_req && in_win && io_ok |=> o_pbus_sel)
		else $error("window reference not claimed");

	a_win_span: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		o_pbus_sel |-> o_paddr >= trim(PBUS_BASE)
		&& ((o_paddr - trim(PBUS_BASE)) >> PBUS_W) == 30'h0)
		else $error("window select outside its span");

	a_win_map: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		o_pbus_sel |-> o_pbus_addr == 18'(o_paddr - trim(PBUS_BASE))
		&& o_pbus_mem == (o_pbus_addr < PBUS_MEM_TOP))
		else $error("window offset wrong");

	a_bm_hit: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		i_bm_req |=> o_bm_valid
		&& o_bm_hit == ($past(i_bm_addr) < PBUS_MEM_TOP))
		else $error("bus master hit wrong");

	a_bm_offset: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		i_bm_req |=> o_bm_paddr[MAP_PAGE_W-1:0]
		== $past(i_bm_addr[MAP_PAGE_W-1:0]))
		else $error("bus master page offset lost");

	a_cfg_claim: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		i_req && in_io && io_ok && !in_win && cfg_hit(pa) && !i_write
		|=> o_cfg_sel)
		else $error("type code read not answered");

	a_cfg_data: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		o_cfg_sel |-> o_cfg_data == ADP_TYPE && !o_write)
		else $error("type code answer wrong");

	a_io_refuse: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		i_req && in_io && !io_ok |=> o_err && !o_io_sel && !o_pbus_sel)
		else $error("bad I/O reference not refused");

	a_bad_size: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		i_req && i_size == SZ_BAD |=> o_err && !o_mem_sel)
		else $error("invalid size not refused");

endmodule // pa_decode

// *** hdl/pa_decode_pkg.sv ***
// Package for the physical address space decoder.
// Assumes a single 200 MHz processor clock and a synchronous reset.
package pa_decode_pkg;
	localparam int VA_W = 32;
	localparam int PA_W = 30;
	localparam int PBUS_W = 18;
	// Default memory/I-O split: upper half of physical space is I/O
	localparam logic [29:0] MEM_LIMIT_DEF = 30'h20000000;
	// Default base of the peripheral bus window inside I/O space
	localparam logic [29:0] PBUS_BASE_DEF = 30'h3FFC0000;
	// Window span 256 KB, memory region is its low 248 KB
	localparam logic [17:0] PBUS_MEM_TOP = 18'h3E000;
	// Map register geometry: 512-byte pages over the memory region
	localparam int MAP_PAGE_W = 9;
	localparam int MAP_IDX_W = 9;
	localparam logic [8:0] MAP_ENTRIES = 9'h1F0;
	localparam int MAP_FRAME_W = 21;
	// Reference sizes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;
	localparam logic [1:0] SZ_BAD = 2'h3; // Refused in every space
	// Adapter configuration register offset inside an adapter region
	localparam logic [29:0] ADP_CFG_OFS = 30'h00000000;
	localparam logic [29:0] ADP_CFG_MASK = 30'h00001FFF;
	// Default adapter region base, at the start of I/O space
	localparam logic [29:0] ADP_BASE_DEF = 30'h20000000;
	// Adapter type code; value arbitrary
	localparam logic [31:0] ADP_TYPE_DEF = 32'h0000A5C3;
endpackage

// *** tb/core_model.sv ***
// Processor core model: issues one reference at a time to the decoder.
// Assumes the decoder takes a request on the rising clock edge.
`timescale 1ns/1ps
module core_model (
	input wire logic i_mclk,
	output logic o_req,
	output logic o_map_en,
	output logic [31:0] o_vaddr,
	output logic [29:0] o_xlat_pa,
	output logic [1:0] o_size,
	output logic o_write
);
	////////////////////////////////////////////////////////////////
	// Quiet until the bench asks for a reference
	initial begin
		{o_req, o_map_en, o_vaddr, o_xlat_pa, o_size, o_write} = '0;
	end
	// The unused address path carries the inverse, so a wrong source
	// select cannot pass by luck; released lines flip for the same reason
	task automatic issue(input logic [31:0] va, input logic map,
		input logic [1:0] sz, input logic wr);
		@(negedge i_mclk);
		o_req <= 1'b1;
		o_map_en <= map;
		o_vaddr <= map ? ~va : va;
		o_xlat_pa <= map ? va[29:0] : ~va[29:0];
		o_size <= sz;
		o_write <= wr;
		@(negedge i_mclk);
		o_req <= 1'b0;
		o_vaddr <= ~o_vaddr;
		o_xlat_pa <= ~o_xlat_pa;
		o_size <= ~sz;
		o_write <= ~wr;
	endtask
endmodule // core_model

// *** tb/testbench.sv ***
// Self-checking bench for the physical address decoder.
// Assumes default decoder parameters and one 200 MHz clock.
`timescale 1ns/1ps
module testbench;
	import pa_decode_pkg::*;
	logic i_mclk, i_rst, i_req, i_map_en, i_write, i_map_we, i_bm_req;
	logic [31:0] i_vaddr;
	logic [29:0] i_xlat_pa;
	logic [1:0] i_size;
	logic [8:0] i_map_idx;
	logic [20:0] i_map_frame;
	logic [17:0] i_bm_addr;
	logic o_mem_sel, o_io_sel, o_pbus_sel, o_pbus_mem, o_cfg_sel, o_write;
	logic o_err, o_bm_valid, o_bm_hit;
	logic [29:0] o_paddr, o_bm_paddr;
	logic [17:0] o_pbus_addr;
	logic [1:0] o_size;
	logic [31:0] o_cfg_data;
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////////
	pa_decode pa_decode_inst (.i_mclk, .i_rst, .i_req, .i_vaddr, .i_map_en,
		.i_xlat_pa, .i_size, .i_write, .i_map_we, .i_map_idx, .i_map_frame,
		.i_bm_req, .i_bm_addr, .o_mem_sel, .o_io_sel, .o_pbus_sel,
		.o_pbus_mem, .o_cfg_sel, .o_paddr, .o_pbus_addr, .o_size, .o_write,
		.o_err, .o_cfg_data, .o_bm_valid, .o_bm_hit, .o_bm_paddr);
	core_model core_model_inst (.i_mclk, .o_req(i_req), .o_map_en(i_map_en),
		.o_vaddr(i_vaddr), .o_xlat_pa(i_xlat_pa), .o_size(i_size),
		.o_write(i_write));
	// Clock, and a cycle ceiling well above the run's length
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic results();
		if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", what, e, g);
			err_total++;
		end
	endtask
	// Sel order: memory, I/O, window, config, error
	task automatic refr(input logic [31:0] va, input logic map,
		input logic [1:0] sz, input logic wr, input logic [4:0] sel);
		core_model_inst.issue(va, map, sz, wr);
		chk("target", {27'h0, sel},
			{27'h0, o_mem_sel, o_io_sel, o_pbus_sel, o_cfg_sel, o_err});
		if (!sel[0]) chk("paddr", {2'h0, va[29:0]}, {2'h0, o_paddr});
		if (!sel[0]) chk("size", {30'h0, sz}, {30'h0, o_size});
		if (!sel[0]) chk("write", {31'h0, wr}, {31'h0, o_write});
	endtask
	task automatic bm(input logic [17:0] a, input logic hit,
		input logic [29:0] pa);
		@(negedge i_mclk);
		i_bm_req = 1'b1;
		i_bm_addr = a;
		@(negedge i_mclk);
		i_bm_req = 1'b0;
		i_bm_addr = ~a;
		chk("bm valid", 32'h1, {31'h0, o_bm_valid});
		chk("bm hit", {31'h0, hit}, {31'h0, o_bm_hit});
		if (hit) chk("bm paddr", {2'h0, pa}, {2'h0, o_bm_paddr});
	endtask
	////////////////////////////////////////////////////////////////
	// Mapping off: top two bits dropped, byte, word and longword; byte and longword at odd addresses
	task automatic t_unmapped();
		for (int s = 0; s < 3; s++) begin
			refr(32'hC0001003 + s, 1'b0, s[1:0], 1'b0, 5'h10);
		end
	endtask
	// Space split boundary, config register and refused I/O forms
	task automatic t_spaces();
		refr(32'h1FFFFFFF, 1'b1, SZ_BYTE, 1'b1, 5'h10);
		refr(32'h20000100, 1'b1, SZ_LONG, 1'b1, 5'h08);
		refr(32'h20000000, 1'b1, SZ_LONG, 1'b0, 5'h02);
		chk("type code", ADP_TYPE_DEF, o_cfg_data);
		refr(32'h20000000, 1'b1, SZ_LONG, 1'b1, 5'h08);
		refr(32'h20000100, 1'b1, SZ_WORD, 1'b0, 5'h01);
		refr(32'h20000102, 1'b1, SZ_LONG, 1'b0, 5'h01);
		refr(32'h00000100, 1'b1, SZ_BAD, 1'b0, 5'h01);
	endtask
	// Window offsets and the edge of its memory region
	task automatic t_window();
		refr(32'hFFFC0100, 1'b0, SZ_LONG, 1'b0, 5'h04);
		chk("bus addr", 32'h00100, {14'h0, o_pbus_addr});
		chk("bus mem", 32'h1, {31'h0, o_pbus_mem});
		refr(32'h3FFFDFFC, 1'b1, SZ_LONG, 1'b0, 5'h04);
		chk("bus mem", 32'h1, {31'h0, o_pbus_mem});
		refr(32'h3FFFE000, 1'b1, SZ_LONG, 1'b0, 5'h04);
		chk("bus addr", 32'h3E000, {14'h0, o_pbus_addr});
		chk("bus mem", 32'h0, {31'h0, o_pbus_mem});
	endtask
	// Bus master translation through two written map entries
	task automatic t_master();
		for (int k = 1; k < 3; k++) begin
			@(negedge i_mclk);
			i_map_we = 1'b1;
			i_map_idx = k[8:0];
			i_map_frame = 21'(21'h0ABCD * k);
			@(negedge i_mclk);
			i_map_we = 1'b0;
		end
		bm(18'h00205, 1'b1, {21'h0ABCD, 9'h005});
		bm(18'h00405, 1'b1, {21'h1579A, 9'h005});
		bm(18'h3E000, 1'b0, 30'h0);
	endtask
	// Reset in mid-run clears the held reference fields
	task automatic t_reset();
		refr(32'h00000010, 1'b0, SZ_LONG, 1'b1, 5'h10);
		i_rst = 1'b1;
		@(negedge i_mclk);
		chk("reset paddr", 32'h0, {2'h0, o_paddr});
		chk("reset write", 32'h0, {31'h0, o_write});
		i_rst = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	// Reset, then each scenario in turn
	initial begin
		i_rst = 1'b1;
		{i_map_we, i_bm_req} = 2'h0;
		{i_map_idx, i_map_frame, i_bm_addr} = '1;
		repeat (2) @(negedge i_mclk);
		chk("idle", 32'h0, {26'h0, o_mem_sel, o_io_sel, o_pbus_sel, o_cfg_sel,
			o_err, o_bm_valid});
		i_rst = 1'b0;
		t_unmapped();
		t_spaces();
		t_window();
		t_reset();
		t_master();
		results();
	end
endmodule // testbench
